// *** hw/ext_port_pkg.sv ***
package ext_port_pkg;

   localparam int addr_width = 16;
   localparam int data_width = 24;
   localparam int mode_bus_bit = 7;
   localparam logic [15:0] addr_reset = 16'h0000;
   localparam logic [23:0] data_reset = 24'h000000;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_access = 3'b001,
      st_finish = 3'b010,
      st_release = 3'b011,
      st_granted = 3'b100
   } port_state_type;

   // Request from the core for one external access
   typedef struct packed {
      logic valid;
      logic write;
      logic program_space;
      logic y_space;
      logic [15:0] addr;
      logic [23:0] wdata;
   } core_req_type;

   // Strobe levels as driven on the pins, active low except X/Y select (high for X)
   typedef struct packed {
      logic program_space_select_n;
      logic data_space_select_n;
      logic xy_select;
      logic read_strobe_n;
      logic write_strobe_n;
   } strobe_type;

   localparam strobe_type strobe_idle = 5'h1f;

endpackage : ext_port_pkg

// *** hw/external_memory_port_bus.sv ***
`timescale 1ns/1ns

// What this block does
// - Drive the 16-bit address bus for every external access.
// - Hold the address bus steady while no external space is accessed.
// - Provide a 24-bit bidirectional data bus for reads and writes.
// - Float the whole data bus while bus grant is asserted.
// - Assert program space select only for external program memory cycles.
// - Assert data space select only for external data memory cycles.
// - Drive X/Y select to mark which data space is referenced.
// - Float program, data and X/Y selects during reset.
// - Assert active-low read strobe for reads; float it during reset.
// - Assert active-low write strobe for writes; float it during reset.
// - Mode bit 7 clear: on bus request float port after access, then grant.
// - Mode bit 7 set: stretch access while wait is asserted; pulse bus strobe.
module external_memory_port_bus (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic mode_bus_wait,
   input wire ext_port_pkg::core_req_type core_req,
   output logic core_ready,
   output logic core_done,
   output logic [23:0] core_rdata,
   output logic [15:0] ext_addr_bus,
   output logic ext_addr_bus_oe_n,
   input wire logic [23:0] ext_data_bus_in,
   output logic [23:0] ext_data_bus,
   output logic ext_data_bus_oe_n,
   output ext_port_pkg::strobe_type strobes,
   output logic strobes_oe_n,
   input wire logic bus_request_n,
   input wire logic wait_request_n,
   output logic bus_grant_n,
   output logic bus_strobe_n,
   output logic bg_bs_oe_n
);

   ext_port_pkg::port_state_type state;
   ext_port_pkg::port_state_type next_state;
   ext_port_pkg::core_req_type cur;
   ext_port_pkg::core_req_type next_cur;
   logic [1:0] req_sync;
   logic [1:0] wait_sync;
   logic [1:0] next_req_sync;
   logic [1:0] next_wait_sync;
   logic [15:0] next_addr;
   logic next_addr_oe_n;
   logic next_data_oe_n;
   logic next_strobes_oe_n;
   logic next_bg_bs_oe_n;
   logic [23:0] next_wdata;
   logic [23:0] next_rdata;
   ext_port_pkg::strobe_type next_strobes;
   logic next_grant_n;
   logic next_bstrobe_n;
   logic next_ready;
   logic next_done;
   logic request_seen;
   logic wait_seen;

   // Pin levels for one access; only one space select can fall
   function automatic ext_port_pkg::strobe_type access_strobes(
      input ext_port_pkg::core_req_type req
   );
      ext_port_pkg::strobe_type s;
      s = ext_port_pkg::strobe_idle;
      s.program_space_select_n = !req.program_space;
      s.data_space_select_n = req.program_space;
      s.xy_select = !req.y_space;
      s.read_strobe_n = req.write;
      s.write_strobe_n = !req.write;
      return s;
   endfunction : access_strobes

   // Pins from the outside world: two flops before use
   // The first stage may be metastable; only the second is read
   always_comb begin
      next_req_sync = {req_sync[0], bus_request_n};
      next_wait_sync = {wait_sync[0], wait_request_n};
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         req_sync <= 2'h3;
         wait_sync <= 2'h3;
      end else begin
         req_sync <= next_req_sync;
         wait_sync <= next_wait_sync;
      end
   end

   // Mode bit comes from core logic on this clock, so it is not synced
   assign request_seen = !req_sync[1] && !mode_bus_wait;
   assign wait_seen = !wait_sync[1] && mode_bus_wait;

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_addr = ext_addr_bus;
      next_addr_oe_n = ext_addr_bus_oe_n;
      next_data_oe_n = 1'b1;
      next_wdata = ext_data_bus;
      next_rdata = core_rdata;
      // Strobes and grant return to idle unless a branch says otherwise
      next_strobes = ext_port_pkg::strobe_idle;
      next_strobes_oe_n = strobes_oe_n;
      next_bg_bs_oe_n = 1'b0;
      next_grant_n = 1'b1;
      next_bstrobe_n = 1'b1;
      next_ready = 1'b0;
      next_done = 1'b0;
      unique case (state)
         ext_port_pkg::st_idle: begin
            // Out of reset the control pins start driving
            next_addr_oe_n = 1'b0;
            next_strobes_oe_n = 1'b0;
            // Bus request wins over a pending core request
            if (request_seen) begin
               next_state = ext_port_pkg::st_release;
            end else if (core_req.valid && core_ready) begin
               next_cur = core_req;
               next_state = ext_port_pkg::st_access;
               next_addr = core_req.addr;
               next_wdata = core_req.wdata;
               next_data_oe_n = !core_req.write;
               next_strobes = access_strobes(core_req);
               next_bstrobe_n = !mode_bus_wait;
            end else begin
               next_ready = 1'b1;
            end
         end

         ext_port_pkg::st_access: begin
            // Wait passes the synchroniser, so it stretches two cycles late
            next_data_oe_n = !cur.write;
            next_strobes = strobes;
            next_bstrobe_n = bus_strobe_n;
            if (!wait_seen) begin
               next_state = ext_port_pkg::st_finish;
            end
         end

         ext_port_pkg::st_finish: begin
            // A request raised mid-access waits for this boundary
            // Address is held, not cleared, to save toggles
            if (!cur.write) begin
               next_rdata = ext_data_bus_in;
            end
            next_done = 1'b1;
            next_ready = !request_seen;
            next_state = ext_port_pkg::st_idle;
         end

         ext_port_pkg::st_release: begin
            // Float first, grant a cycle later, so two masters never overlap
            next_addr_oe_n = 1'b1;
            next_strobes_oe_n = 1'b1;
            next_state = ext_port_pkg::st_granted;
         end
         ext_port_pkg::st_granted: begin
            next_addr_oe_n = 1'b1;
            next_strobes_oe_n = 1'b1;
            // Grant only after the port is already floated
            next_grant_n = !request_seen;
            if (!request_seen) begin
               next_state = ext_port_pkg::st_idle;
            end
         end

         default: begin
            // Illegal codes fall back to idle
            next_state = ext_port_pkg::st_idle;
         end
      endcase
   end

   // Every output comes straight from these flops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         // Pins float until the first edge after reset
         state <= ext_port_pkg::st_idle;
         cur <= '0;
         ext_addr_bus <= ext_port_pkg::addr_reset;
         ext_addr_bus_oe_n <= 1'b1;
         ext_data_bus <= ext_port_pkg::data_reset;
         ext_data_bus_oe_n <= 1'b1;
         core_rdata <= ext_port_pkg::data_reset;
         strobes <= ext_port_pkg::strobe_idle;
         strobes_oe_n <= 1'b1;
         bg_bs_oe_n <= 1'b1;
         bus_grant_n <= 1'b1;
         bus_strobe_n <= 1'b1;
         core_ready <= 1'b0;
         core_done <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         ext_addr_bus <= next_addr;
         ext_addr_bus_oe_n <= next_addr_oe_n;
         ext_data_bus <= next_wdata;
         ext_data_bus_oe_n <= next_data_oe_n;
         core_rdata <= next_rdata;
         strobes <= next_strobes;
         strobes_oe_n <= next_strobes_oe_n;
         bg_bs_oe_n <= next_bg_bs_oe_n;
         bus_grant_n <= next_grant_n;
         bus_strobe_n <= next_bstrobe_n;
         core_ready <= next_ready;
         core_done <= next_done;
      end
   end

endmodule : external_memory_port_bus

// *** verif/ext_mem_model.sv ***
`timescale 1ns/1ns
module ext_mem_model (
   input wire logic clk_sys,
   input wire logic [15:0] ext_addr_bus,
   input wire ext_port_pkg::strobe_type strobes,
   input wire logic strobes_oe_n,
   input wire logic [23:0] ext_data_bus,
   input wire logic ext_data_bus_oe_n,
   output logic [23:0] bus_level
);
   logic [23:0] mem [0:63];
   logic [23:0] last = 24'h000000;
   wire p_n = strobes.program_space_select_n;
   wire [5:0] idx = {p_n, p_n & strobes.xy_select, ext_addr_bus[3:0]};
   wire rd = !strobes_oe_n && !strobes.read_strobe_n;
   always @(posedge clk_sys) begin
      if (!strobes_oe_n && !strobes.write_strobe_n) mem[idx] <= ext_data_bus;
      if (rd) last <= mem[idx];
   end
   // Released bus shows the inverse, so a late sample cannot pass by luck
   assign bus_level = !ext_data_bus_oe_n ? ext_data_bus : rd ? mem[idx] : ~last;
endmodule : ext_mem_model

// *** verif/external_memory_port_bus_assertions.sv ***
`timescale 1ns/1ns
module external_memory_port_bus_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic mode_bus_wait,
   input wire logic core_ready,
   input wire logic core_done,
   input wire logic [15:0] ext_addr_bus,
   input wire logic ext_addr_bus_oe_n,
   input wire logic ext_data_bus_oe_n,
   input wire ext_port_pkg::strobe_type strobes,
   input wire logic strobes_oe_n,
   input wire logic bus_grant_n,
   input wire logic bus_strobe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire idle_rw = strobes.read_strobe_n & strobes.write_strobe_n;
   a_sel_excl: assert property (strobes.program_space_select_n | strobes.data_space_select_n)
      else $error("both space selects low");
   a_grant_float: assert property (!bus_grant_n |-> ext_addr_bus_oe_n && ext_data_bus_oe_n && strobes_oe_n)
      else $error("port driven while granted");
   a_grant_after: assert property ($fell(bus_grant_n) |-> $past(strobes_oe_n) && $past(ext_addr_bus_oe_n))
      else $error("grant before release");
   a_addr_hold: assert property (core_ready && $past(core_ready) |-> $stable(ext_addr_bus))
      else $error("address moved while idle");
   a_read_float: assert property (!strobes.read_strobe_n |-> ext_data_bus_oe_n && strobes.write_strobe_n)
      else $error("data driven in read");
   a_write_drive: assert property (!strobes.write_strobe_n |-> !ext_data_bus_oe_n)
      else $error("data not driven in write");
   a_access_len: assert property (!mode_bus_wait && $fell(idle_rw) |=> !idle_rw ##1 core_done)
      else $error("access length wrong");
   a_bus_strobe: assert property (mode_bus_wait && $fell(idle_rw) |-> !bus_strobe_n)
      else $error("bus strobe missing");
   cover property (!bus_grant_n);
   cover property (mode_bus_wait && core_done);
   cover property (!strobes.write_strobe_n && !strobes.program_space_select_n);
endmodule : external_memory_port_bus_checker

// *** verif/external_memory_port_bus_test.sv ***
`timescale 1ns/1ns
module external_memory_port_bus_test;
   logic clk_sys = 0, nrst = 0, mode_bus_wait = 0, bus_request_n = 1, wait_request_n = 1;
   ext_port_pkg::core_req_type core_req = '0;
   ext_port_pkg::strobe_type strobes;
   logic core_ready, core_done, ext_addr_bus_oe_n, ext_data_bus_oe_n, strobes_oe_n;
   logic bus_grant_n, bus_strobe_n, bg_bs_oe_n;
   logic [23:0] core_rdata, ext_data_bus, bus_level;
   logic [15:0] ext_addr_bus;
   int fail_count = 0, comparisons = 0, cycles = 0, n;
   external_memory_port_bus u_external_memory_port_bus (.clk_sys, .nrst, .mode_bus_wait,
      .core_req, .core_ready, .core_done, .core_rdata, .ext_addr_bus, .ext_addr_bus_oe_n,
      .ext_data_bus_in(bus_level), .ext_data_bus, .ext_data_bus_oe_n, .strobes, .strobes_oe_n,
      .bus_request_n, .wait_request_n, .bus_grant_n, .bus_strobe_n, .bg_bs_oe_n);
   ext_mem_model u_ext_mem_model (.clk_sys, .ext_addr_bus, .strobes, .strobes_oe_n,
      .ext_data_bus, .ext_data_bus_oe_n, .bus_level);
   task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic access(logic w, logic p, logic y, logic [15:0] a, logic [23:0] d);
      while (core_ready !== 1) @(negedge clk_sys);
      core_req = '{1'b1, w, p, y, a, d};
      @(negedge clk_sys);
      core_req.valid = 0;
      chk("addr", a, ext_addr_bus);
      chk("strobes", {!p, p, !y, w, !w}, strobes);
      chk("data oe", !w, ext_data_bus_oe_n);
      chk("bus strobe", !mode_bus_wait, bus_strobe_n);
      for (n = 1; core_done !== 1 && n < 40; n++) @(negedge clk_sys);
      if (!w) chk("rdata", d, core_rdata);
   endtask : access
   task automatic t_spaces;
      // Same address in all three spaces, so a space mix-up reads wrong data
      for (int i = 0; i < 6; i++) access(i < 3, i % 3 == 2, i % 3 == 1, 16'hfff5, 24'h5a5a00 + i % 3);
   endtask : t_spaces
   task automatic t_wait;
      mode_bus_wait = 1;
      wait_request_n = 0;
      // Let wait pass the synchroniser before the access is taken
      repeat (3) @(negedge clk_sys);
      fork
         access(0, 0, 1, 16'hfff5, 24'h5a5a01);
         repeat (6) @(negedge clk_sys);
      join_any
      wait_request_n = 1;
      wait fork;
      chk("wait stretch", 1, n > 5);
      mode_bus_wait = 0;
   endtask : t_wait
   task automatic t_grant;
      bus_request_n = 0;
      for (n = 0; bus_grant_n !== 0 && n < 10; n++) @(negedge clk_sys);
      chk("float", 5'h1f, {!bus_grant_n, ext_addr_bus_oe_n, ext_data_bus_oe_n, strobes_oe_n, !core_ready});
      bus_request_n = 1;
      access(0, 1, 0, 16'hfff5, 24'h5a5a02);
   endtask : t_grant
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (++cycles == 3000) begin
         fail_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      chk("reset float", 4'hf, {strobes_oe_n, ext_addr_bus_oe_n, ext_data_bus_oe_n, bg_bs_oe_n});
      nrst = 1;
      t_spaces;
      t_wait;
      t_grant;
      report_and_stop;
   end
endmodule : external_memory_port_bus_test
bind external_memory_port_bus external_memory_port_bus_checker u_external_memory_port_bus_checker (
   .clk_sys, .nrst, .mode_bus_wait, .core_ready, .core_done, .ext_addr_bus, .ext_addr_bus_oe_n,
   .ext_data_bus_oe_n, .strobes, .strobes_oe_n, .bus_grant_n, .bus_strobe_n);
